/* File: common/asb_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the serial buffer engine.
// Assumes: Included by bare name from the transfer engine design file and the testbench.
// Notes: Definitions only; no logic lives here.
`ifndef ASB_DEFS_SVH
`define ASB_DEFS_SVH
`define ASB_OFS_MODE 8'h00
`define ASB_OFS_ACTRL 8'h04
`define ASB_OFS_GAP 8'h08
`define ASB_OFS_PTR 8'h0C
`define ASB_OFS_SHIFT 8'h10
`define ASB_OFS_STAT 8'h14
`define ASB_RAM_SEL_BIT 7
`define ASB_MODE_ON_BIT 7
`define ASB_MODE_AUTO_BIT 5
`define ASB_MODE_MST_BIT 0
`define ASB_MODE_WMASK 8'hA1
`define ASB_ACTRL_RX_BIT 7
`define ASB_ACTRL_BUSY_BIT 3
`define ASB_ACTRL_WMASK 8'hC3
`define ASB_GAP_WMASK 8'h9F
`define ASB_RESET_VAL 8'h00
`define ASB_FIN_HALVES 7'h04
`define ASB_GAP_ZERO_HALVES 7'h04
`define ASB_GAP_ADD_HALVES 7'h02
`define ASB_LAST_BIT 3'h7
`define ASB_PCLK_NS 20
`define ASB_SCK_NS 800
`define ASB_SCK_HALF_CYC ((`ASB_SCK_NS / 2 + `ASB_PCLK_NS - 1) / `ASB_PCLK_NS)
`endif

/* File: common/asb_pkg.sv */
// Purpose: Shared types of the serial buffer engine.
// Assumes: Constants come from asb_defs.svh.
// Notes: Types only.
package asb_pkg;
  typedef logic [7:0] apb_addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_FETCH = 3'b010,
    ST_GAP = 3'b011,
    ST_SHIFT = 3'b100,
    ST_STORE = 3'b101,
    ST_FINISH = 3'b110
  } eng_state_t;
endpackage : asb_pkg

/* File: common/ram_port_if.sv */
// Purpose: Carries the engine and CPU access paths to the buffer RAM.
// Assumes: One clock; the RAM answers reads one cycle after the request.
// Notes: The engine port always wins; the CPU port waits for its grant.
`timescale 1ns/1ns
`default_nettype none
interface ram_port_if #(parameter int unsigned AW = 5);
  logic eng_req;
  logic eng_we;
  logic [AW-1:0] eng_addr;
  logic [7:0] eng_wdata;
  logic cpu_req;
  logic cpu_we;
  logic [AW-1:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_gnt;
  logic [7:0] rdata;
  modport mem (input eng_req, eng_we, eng_addr, eng_wdata, cpu_req, cpu_we, cpu_addr, cpu_wdata,
    output cpu_gnt, rdata);
  modport user (output eng_req, eng_we, eng_addr, eng_wdata, cpu_req, cpu_we, cpu_addr, cpu_wdata,
    input cpu_gnt, rdata);
endinterface : ram_port_if
`default_nettype wire

/* File: design/buffer_ram.sv */
// Purpose: Byte-wide buffer RAM shared by the transfer engine and the CPU.
// Assumes: Synchronous read with one cycle of latency.
// Notes: The engine has priority, so a CPU access can be stretched while a byte is stored or fetched.
`timescale 1ns/1ns
`default_nettype none
module buffer_ram #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic pclk, // System clock.
  ram_port_if.mem port // Engine and CPU access paths.
);
  logic [7:0] mem_q [DEPTH]; // Storage array, no reset needed.
  logic [7:0] rdata_q; // Registered read data.

  // The CPU is granted only when the engine leaves the RAM free.
  assign port.cpu_gnt = port.cpu_req & ~port.eng_req;
  assign port.rdata = rdata_q;

  // One access per cycle; the engine takes precedence over the CPU.
  always_ff @(posedge pclk) begin
    if (port.eng_req) begin
      if (port.eng_we) begin
        mem_q[port.eng_addr] <= port.eng_wdata;
      end
      rdata_q <= mem_q[port.eng_addr];
    end else if (port.cpu_req) begin
      if (port.cpu_we) begin
        mem_q[port.cpu_addr] <= port.cpu_wdata;
      end
      rdata_q <= mem_q[port.cpu_addr];
    end
  end
endmodule : buffer_ram
`default_nettype wire

/* File: design/auto_serial_buffer_transfer.sv */
// Purpose: Automatic multi-byte transfer between a 32-byte buffer RAM and a 3-wire serial link.
// Assumes: APB slave on pclk; the serial clock is either generated here or sampled from the pin.
// Notes: Repeat mode, suspend and busy handshaking are not implemented; the wait pin is a plain input.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "asb_defs.svh"

// Behaviour
// RQ1: Inter-byte gap follows the interval field.
// RQ2: Software leaves interval alone while running.
// RQ3: Software writes zero to interval bits five, six.
// RQ4: Wait pin never stalls interval-timed transfers.
// RQ5: Bytes sit upward from RAM base, first highest.
// RQ6: Software loads pointer with count minus one.
// RQ7: Software enables, selects receive, then writes shifter.
// RQ8: Shifter write only starts; data discarded.
// RQ9: Send RAM byte at pointer, store reply there.
// RQ10: Decrement pointer; stop after byte zero.
// RQ11: Clear busy flag when the sequence ends.
// RQ12: Master ends two clocks after last byte.
// RQ13: Slave ends on next rising serial clock.
// RQ14: Acknowledge clears the interrupt flag.
// RQ15: Wait pin free when handshaking unused.
// RQ16: Without receive, transmit only, store nothing.
// RQ17: Data output low while busy flag clear.
// RQ18: RAM access gap follows every byte.
// RQ19: Software keeps repeat bit zero.
// RQ20: Store reply, decrement, then load next byte.
// RQ21: Five-bit pointer holds while idle.
module auto_serial_buffer_transfer #(
  parameter int unsigned SCK_HALF_CYC = `ASB_SCK_HALF_CYC, // Master serial clock half period in pclk cycles.
  parameter int unsigned RAM_DEPTH = 32 // Buffer RAM size in bytes.
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire asb_pkg::apb_addr_t paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic sck_in, // Serial clock pin input.
  output logic sck_out, // Serial clock pin output.
  output logic sck_oe, // Serial clock pin output enable.
  input wire logic ser_in_pin, // Serial data input pin.
  output logic ser_out_pin, // Serial data output pin.
  output logic ser_out_oe, // Serial data output enable.
  input wire logic wait_in_pin, // Remote busy input, read as a port pin.
  input wire logic irq_ack, // Interrupt acknowledge pulse.
  output logic serial_irq_flag // Completion interrupt flag.
);
  import asb_pkg::*;

  localparam int unsigned AW = $clog2(RAM_DEPTH); // Pointer width.
  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF_CYC - 1); // Divider reload value.

  // Software-visible registers.
  byte_t serial_mode_reg_q; // Enable, auto mode and clock master bits.
  byte_t auto_ctrl_reg_q; // Receive, repeat and busy option bits.
  byte_t xfer_gap_reg_q; // Interval field in the low five bits.
  logic [AW-1:0] buf_pointer_q; // Down-counting RAM pointer.
  logic xfer_busy_flag_q; // Automatic sequence running.
  logic serial_irq_flag_q; // Completion flag.

  // APB slave state.
  logic [31:0] prdata_q; // Registered read data.
  logic pready_q; // Registered ready.
  logic pslverr_q; // Registered error.
  logic ram_got_q; // CPU RAM access granted, data due.

  // Engine state.
  eng_state_t state_q; // Sequencer state.
  byte_t shift_reg_q; // Serial shift register.
  logic in_bit_q; // Last bit sampled on a rising edge.
  logic [2:0] bit_cnt_q; // Rising edges seen in this byte.
  logic first_q; // Next fetched byte is the first one.
  logic [6:0] gap_cnt_q; // Half periods still to wait.
  logic [7:0] div_q; // Half period divider.
  logic sck_q; // Generated serial clock.
  logic ser_out_q; // Data output level.
  logic sck_oe_q; // Clock drive enable.
  logic ser_oe_q; // Data drive enable.

  // Pin synchronisers; the first stage feeds only the second.
  logic sck_s1_q, sck_s2_q, sck_s3_q; // Clock pin and edge history.
  logic sin_s1_q, sin_s2_q; // Data input pin.
  logic wait_s1_q, wait_s2_q; // Wait pin.

  ram_port_if #(.AW(AW)) ram (); // Buffer RAM access paths.

  buffer_ram #(.DEPTH(RAM_DEPTH), .AW(AW)) u_ram (
    .pclk(pclk),
    .port(ram.mem)
  );

  // Gap length in half periods, less the one spent starting the byte.
  function automatic logic [6:0] gap_halves(input logic [4:0] n);
    logic [6:0] h;
    h = {1'b0, n, 1'b0} + `ASB_GAP_ADD_HALVES;
    return (n == 5'h00) ? `ASB_GAP_ZERO_HALVES : h;
  endfunction : gap_halves

  // Decode helpers.
  logic acc; // APB access phase.
  logic is_ram; // Address falls in the RAM window.
  logic known; // Address is mapped.
  logic wr; // Register write takes effect this edge.
  logic start; // Trigger from a shifter write.
  logic master; // Serial clock generated here.
  logic rx_on; // Receive enabled.
  logic half_tick; // Master half period strobe.
  logic rise_ev; // Serial clock rising edge in a byte.
  logic fall_ev; // Serial clock falling edge in a byte.
  logic s_rise; // External clock rising edge.
  logic s_fall; // External clock falling edge.
  logic last_rise; // Eighth rising edge of a byte.
  byte_t reg_rd; // Register read mux.
  byte_t rx_byte; // Completed received byte.

  always_comb begin
    acc = psel & penable;
    is_ram = paddr[`ASB_RAM_SEL_BIT];
    known = is_ram | (paddr == `ASB_OFS_MODE) | (paddr == `ASB_OFS_ACTRL) | (paddr == `ASB_OFS_GAP)
      | (paddr == `ASB_OFS_PTR) | (paddr == `ASB_OFS_SHIFT) | (paddr == `ASB_OFS_STAT);
    wr = acc & pready_q & pwrite & ~is_ram;
    master = serial_mode_reg_q[`ASB_MODE_MST_BIT];
    rx_on = auto_ctrl_reg_q[`ASB_ACTRL_RX_BIT];
    start = wr & (paddr == `ASB_OFS_SHIFT) & serial_mode_reg_q[`ASB_MODE_ON_BIT]
      & serial_mode_reg_q[`ASB_MODE_AUTO_BIT] & ~xfer_busy_flag_q; // RQ8
    half_tick = xfer_busy_flag_q & (div_q == 8'h00);
    s_rise = sck_s2_q & ~sck_s3_q;
    s_fall = ~sck_s2_q & sck_s3_q;
    rise_ev = (state_q == ST_SHIFT) & (master ? (half_tick & ~sck_q) : s_rise);
    fall_ev = (state_q == ST_SHIFT) & (master ? (half_tick & sck_q) : s_fall);
    last_rise = rise_ev & (bit_cnt_q == `ASB_LAST_BIT);
    rx_byte = {shift_reg_q[6:0], in_bit_q};
  end

  // Register read mux; reserved bits read as zero.
  always_comb begin
    reg_rd = `ASB_RESET_VAL;
    case (paddr)
      `ASB_OFS_MODE: reg_rd = serial_mode_reg_q;
      `ASB_OFS_ACTRL: begin
        reg_rd = auto_ctrl_reg_q;
        reg_rd[`ASB_ACTRL_BUSY_BIT] = xfer_busy_flag_q;
      end
      `ASB_OFS_GAP: reg_rd = xfer_gap_reg_q;
      `ASB_OFS_PTR: reg_rd = 8'(buf_pointer_q);
      `ASB_OFS_SHIFT: reg_rd = shift_reg_q;
      `ASB_OFS_STAT: reg_rd = {5'h00, sin_s2_q, wait_s2_q, serial_irq_flag_q}; // RQ15 RQ16
      default: reg_rd = `ASB_RESET_VAL;
    endcase
  end

  // RAM ports: the engine reads while loading and, with receive on, writes while storing.
  always_comb begin
    ram.eng_req = (state_q == ST_LOAD) | ((state_q == ST_STORE) & rx_on); // RQ9 RQ16
    ram.eng_we = (state_q == ST_STORE);
    ram.eng_addr = buf_pointer_q; // RQ9
    ram.eng_wdata = rx_byte;
    ram.cpu_req = acc & is_ram & ~pready_q & ~ram_got_q;
    ram.cpu_we = pwrite;
    ram.cpu_addr = paddr[AW+1:2];
    ram.cpu_wdata = pwdata[7:0];
  end

  // Synchronise every pin before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      sin_s1_q <= 1'b0;
      sin_s2_q <= 1'b0;
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sin_s1_q <= ser_in_pin;
      sin_s2_q <= sin_s1_q;
      wait_s1_q <= wait_in_pin;
      wait_s2_q <= wait_s1_q;
    end
  end

  // APB answer: registers answer one cycle into the access phase, RAM two cycles after its grant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ram_got_q <= 1'b0;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      if (ram.cpu_gnt) begin
        ram_got_q <= 1'b1;
      end else if (pready_q) begin
        ram_got_q <= 1'b0;
      end
      if (acc & ~pready_q) begin
        if (!is_ram) begin
          pready_q <= 1'b1;
          pslverr_q <= ~known;
          prdata_q <= {24'h00_0000, reg_rd};
        end else if (ram_got_q) begin
          pready_q <= 1'b1;
          prdata_q <= {24'h00_0000, ram.rdata};
        end
      end
    end
  end

  // Control register writes; the written value goes in at the ready edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_reg_q <= `ASB_RESET_VAL;
      auto_ctrl_reg_q <= `ASB_RESET_VAL;
      xfer_gap_reg_q <= `ASB_RESET_VAL;
    end else if (wr) begin
      if (paddr == `ASB_OFS_MODE) begin
        serial_mode_reg_q <= pwdata[7:0] & `ASB_MODE_WMASK;
      end
      if (paddr == `ASB_OFS_ACTRL) begin
        auto_ctrl_reg_q <= pwdata[7:0] & `ASB_ACTRL_WMASK;
      end
      // Bits five and six stay zero whatever is written.
      if (paddr == `ASB_OFS_GAP) begin
        xfer_gap_reg_q <= pwdata[7:0] & `ASB_GAP_WMASK;
      end
    end
  end

  // Pointer: software loads it only while idle, the engine counts it down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_pointer_q <= '0;
    end else if (!xfer_busy_flag_q) begin
      if (wr & (paddr == `ASB_OFS_PTR)) begin
        buf_pointer_q <= pwdata[AW-1:0]; // RQ21
      end
    end else if ((state_q == ST_STORE) & (buf_pointer_q != '0)) begin
      buf_pointer_q <= buf_pointer_q - 1'b1; // RQ10 RQ20
    end
  end

  // Sequencer: fetch, shift, store, then wait out the gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      first_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_LOAD;
            first_q <= 1'b1;
          end
        end
        ST_LOAD: state_q <= ST_FETCH; // RQ20
        ST_FETCH: begin
          first_q <= 1'b0;
          state_q <= first_q ? ST_SHIFT : ST_GAP; // RQ18
        end
        // Interval timing alone decides the restart; the wait pin is never consulted.
        ST_GAP: begin
          if (gap_cnt_q == 7'h00) begin
            state_q <= ST_SHIFT; // RQ1 RQ4
          end
        end
        ST_SHIFT: begin
          if (last_rise) begin
            state_q <= ST_STORE;
          end
        end
        ST_STORE: state_q <= (buf_pointer_q == '0) ? ST_FINISH : ST_LOAD; // RQ10 RQ20
        ST_FINISH: begin
          if (master ? (gap_cnt_q == 7'h00) : s_rise) begin
            state_q <= ST_IDLE; // RQ12 RQ13
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Busy and interrupt flags; a completion in the acknowledge cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_busy_flag_q <= 1'b0;
      serial_irq_flag_q <= 1'b0;
    end else begin
      if (start) begin
        xfer_busy_flag_q <= 1'b1;
      end
      if ((state_q == ST_FINISH) & (master ? (gap_cnt_q == 7'h00) : s_rise)) begin
        xfer_busy_flag_q <= 1'b0; // RQ11 RQ12 RQ13
        serial_irq_flag_q <= 1'b1; // RQ12 RQ13
      end else if (irq_ack) begin
        serial_irq_flag_q <= 1'b0; // RQ14
      end
    end
  end

  // Gap counter: loaded at the last rising edge of a byte, counts master half periods.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt_q <= 7'h00;
    end else if (last_rise) begin
      if (!master) begin
        gap_cnt_q <= 7'h00;
      end else if (buf_pointer_q == '0) begin
        gap_cnt_q <= `ASB_FIN_HALVES; // RQ12
      end else begin
        gap_cnt_q <= gap_halves(xfer_gap_reg_q[4:0]); // RQ1
      end
    end else if (half_tick & (gap_cnt_q != 7'h00)) begin
      gap_cnt_q <= gap_cnt_q - 7'h01;
    end
  end

  // Half period divider; it only runs during a sequence so each one starts in phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (!xfer_busy_flag_q || div_q == 8'h00) begin
      div_q <= HALF_M1;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // Generated serial clock idles high and toggles only while a byte shifts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
      sck_oe_q <= 1'b0;
      ser_oe_q <= 1'b0;
    end else begin
      sck_oe_q <= master & serial_mode_reg_q[`ASB_MODE_ON_BIT];
      ser_oe_q <= serial_mode_reg_q[`ASB_MODE_ON_BIT];
      if (!master || state_q != ST_SHIFT) begin
        sck_q <= 1'b1;
      end else if (half_tick) begin
        sck_q <= ~sck_q;
      end
    end
  end

  // Shifter: load from RAM, drive on falling edges, sample on rising edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg_q <= `ASB_RESET_VAL;
      in_bit_q <= 1'b0;
      bit_cnt_q <= 3'h0;
      ser_out_q <= 1'b0;
    end else begin
      if (state_q == ST_FETCH) begin
        shift_reg_q <= ram.rdata; // RQ9
        bit_cnt_q <= 3'h0;
      end else if (state_q == ST_STORE) begin
        shift_reg_q <= rx_byte;
      end else if (rise_ev) begin
        in_bit_q <= sin_s2_q;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end else if (fall_ev & (bit_cnt_q != 3'h0)) begin
        shift_reg_q <= {shift_reg_q[6:0], in_bit_q};
      end
      // The line drops low in the very cycle the busy flag clears, so no stale last bit lingers.
      if (!xfer_busy_flag_q | ((state_q == ST_FINISH) & (master ? (gap_cnt_q == 7'h00) : s_rise))) begin
        ser_out_q <= 1'b0; // RQ17
      end else if (state_q == ST_FETCH) begin
        ser_out_q <= ram.rdata[7];
      end else if (fall_ev & (bit_cnt_q != 3'h0)) begin
        ser_out_q <= shift_reg_q[6];
      end
    end
  end

  // Outputs come straight from their flip-flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sck_out = sck_q;
  assign sck_oe = sck_oe_q;
  assign ser_out_pin = ser_out_q;
  assign ser_out_oe = ser_oe_q;
  assign serial_irq_flag = serial_irq_flag_q;
endmodule : auto_serial_buffer_transfer
`default_nettype wire

/* File: tb/serial_peer.sv */
// Purpose: Remote serial peripheral on the 3-wire link.
// Assumes: Follows the engine clock as master, makes its own clock as slave.
// Notes: Reply byte j is 3C xor j; the gap before each byte after the first is timed.
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
  input wire logic sck_out, // Engine clock.
  input wire logic sck_oe, // High while the engine drives the clock.
  input wire logic ser_out_pin, // Engine data.
  output logic sck_in, // Our clock in slave runs.
  output logic ser_in_pin // Our data.
);
  import asb_pkg::*;
  byte_t rx_q [0:31]; // Received bytes in arrival order.
  byte_t sh_q; // Byte being shifted in.
  byte_t rep_q; // Reply byte.
  int rx_cnt; // Whole bytes received.
  int bit_cnt; // Bits of the current byte.
  time rise_t; // Time of the closing edge of the last byte.
  time gap_ns; // Last gap from closing edge to next first fall.
  wire logic sck = sck_oe ? sck_out : sck_in;

  // Clears the counts before each run.
  task automatic clr();
    rx_cnt = 0;
    bit_cnt = 0;
  endtask : clr

  initial begin
    sck_in = 1'b1;
    ser_in_pin = 1'b0;
    clr();
  end

  // Data leaves MSB first after each falling edge.
  always @(negedge sck) begin
    if (bit_cnt == 0 && rx_cnt > 0) begin
      gap_ns = $time - rise_t;
    end
    rep_q = 8'h3C ^ 8'(rx_cnt);
    ser_in_pin = rep_q[3'(7 - bit_cnt)];
  end

  // Capture on the rising edge; a released line shows the inverse, not the old bit.
  always @(posedge sck) begin
    sh_q = {sh_q[6:0], ser_out_pin};
    bit_cnt++;
    if (bit_cnt == 8) begin
      rx_q[rx_cnt[4:0]] = sh_q;
      rx_cnt++;
      bit_cnt = 0;
      rise_t = $time;
      ser_in_pin <= #60 ~ser_in_pin;
    end
  end

  // Slave clocking at 160 ns, still between bytes; one extra pulse closes the run.
  task automatic run_slave(input int nb);
    #37;
    for (int i = 0; i < nb * 8 + 1; i++) begin
      sck_in = 1'b0;
      #80;
      sck_in = 1'b1;
      #80;
      if (i % 8 == 7) #320;
    end
  endtask : run_slave
endmodule : serial_peer
`default_nettype wire

/* File: tb/asb_checker.sv */
// Purpose: Port checks of the serial buffer engine.
// Assumes: One clock domain; bound to the top module.
// Notes: The end delay allows three cycles of slack.
`timescale 1ns/1ns
`default_nettype none
module asb_checker #(
  parameter int unsigned SCK_HALF_CYC = 4 // Serial half period in cycles.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire asb_pkg::apb_addr_t paddr, // APB address.
  input wire logic pready, // APB ready.
  input wire logic sck_out, // Serial clock.
  input wire logic sck_oe, // Serial clock enable.
  input wire logic ser_out_pin, // Data out.
  input wire logic ser_out_oe, // Data out enable.
  input wire logic irq_ack, // Acknowledge.
  input wire logic serial_irq_flag // Interrupt flag.
);
  import asb_pkg::*;
  logic [7:0] hi_q; // Cycles the serial clock has stood high.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Saturates so a long idle never wraps into a legal-looking count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 8'h00;
    end else begin
      hi_q <= !sck_out ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
    end
  end

  end_delay_a: assert property ($rose(serial_irq_flag) && sck_oe |->
    hi_q >= 8'(4 * SCK_HALF_CYC - 3) && hi_q <= 8'(4 * SCK_HALF_CYC + 3)) else $error("End delay wrong.");
  end_clk_idle_a: assert property ($rose(serial_irq_flag) && sck_oe |-> sck_out [*8])
    else $error("Clock moved after end.");
  end_low_a: assert property ($rose(serial_irq_flag) |-> !ser_out_pin [*8])
    else $error("Data out not low at end.");
  ack_clear_a: assert property (irq_ack |=> !serial_irq_flag)
    else $error("Acknowledge left flag set.");
  flag_hold_a: assert property (serial_irq_flag && !irq_ack |=> serial_irq_flag)
    else $error("Flag dropped without acknowledge.");
  reg_ready_a: assert property ($rose(penable) && psel && !paddr[7] |=> pready)
    else $error("Register access not answered.");
  ram_wait_a: assert property ($rose(penable) && psel && paddr[7] |=> !pready)
    else $error("Buffer access answered too soon.");
  pins_oe_a: assert property (sck_oe |-> ser_out_oe)
    else $error("Data out not enabled.");
endmodule : asb_checker

bind auto_serial_buffer_transfer asb_checker #(.SCK_HALF_CYC(SCK_HALF_CYC)) asb_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .sck_out(sck_out), .sck_oe(sck_oe), .ser_out_pin(ser_out_pin), .ser_out_oe(ser_out_oe),
  .irq_ack(irq_ack), .serial_irq_flag(serial_irq_flag));
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the serial buffer engine.
// Assumes: 50 MHz pclk; serial half period cut to 4 cycles.
// Notes: Registers over APB; serial_peer is the far side.
`timescale 1ns/1ns
`default_nettype none
`include "asb_defs.svh"
module tb;
  import asb_pkg::*;
  localparam int unsigned HALF = 4; // Serial half period in cycles.
  logic pclk, presetn, psel, penable, pwrite, irq_ack, wait_in_pin, er;
  apb_addr_t paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sck_in, sck_out, sck_oe, ser_in_pin, ser_out_pin, ser_out_oe, serial_irq_flag;
  int miscompares, tests_run;
  int nb_t [4] = '{32, 2, 2, 1}; // Bytes per run; 32 fills the buffer.
  int gap_t [4] = '{0, 1, 31, 0}; // Interval field per run.
  logic rx_t [4] = '{1'b1, 1'b0, 1'b1, 1'b1}; // Receive enable per run.
  logic mst_t [4] = '{1'b1, 1'b1, 1'b1, 1'b0}; // Clock master per run.

  auto_serial_buffer_transfer #(.SCK_HALF_CYC(HALF)) auto_serial_buffer_transfer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .ser_in_pin(ser_in_pin), .ser_out_pin(ser_out_pin),
    .ser_out_oe(ser_out_oe), .wait_in_pin(wait_in_pin), .irq_ack(irq_ack), .serial_irq_flag(serial_irq_flag));
  serial_peer serial_peer_inst (.sck_out(sck_out), .sck_oe(sck_oe), .ser_out_pin(ser_out_pin),
    .sck_in(sck_in), .ser_in_pin(ser_in_pin));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Counts and reports one comparison.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input apb_addr_t a, input logic w, input byte_t wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One automatic run; the wait pin is raised in transmit-only runs and must not stall them.
  task automatic run(input int nb, input int gn, input logic rx, input logic mst);
    wait_in_pin <= ~rx;
    for (int k = 0; k < nb; k++) apb(8'(8'h80 + 4 * k), 1'b1, 8'(8'h51 + k));
    serial_peer_inst.clr();
    apb(`ASB_OFS_PTR, 1'b1, 8'(nb - 1));
    apb(`ASB_OFS_MODE, 1'b1, {3'h5, 4'h0, mst});
    apb(`ASB_OFS_ACTRL, 1'b1, {rx, 7'h00});
    apb(`ASB_OFS_GAP, 1'b1, 8'(8'h80 | gn));
    apb(`ASB_OFS_SHIFT, 1'b1, 8'hFF);
    if (!mst) serial_peer_inst.run_slave(nb);
    rd = 32'h00000008;
    while (rd[`ASB_ACTRL_BUSY_BIT] !== 1'b0) apb(`ASB_OFS_ACTRL, 1'b0, 8'h00);
    chk({31'h0, serial_irq_flag}, 32'h1);
    apb(`ASB_OFS_STAT, 1'b0, 8'h00);
    chk(rd & 32'h3, {30'h0, ~rx, 1'b1});
    chk({31'h0, ser_out_pin}, 32'h0);
    chk(32'(serial_peer_inst.rx_cnt), 32'(nb));
    for (int j = 0; j < nb; j++) chk({24'h0, serial_peer_inst.rx_q[j]}, 32'(8'h51 + nb - 1 - j));
    for (int k = 0; k < nb; k++) begin
      apb(8'(8'h80 + 4 * k), 1'b0, 8'h00);
      chk(rd, rx ? 32'(8'h3C ^ 8'(nb - 1 - k)) : 32'(8'h51 + k));
    end
    if (mst && nb > 1) chk(32'(serial_peer_inst.gap_ns), 32'(HALF * 20 * (gn == 0 ? 5 : 2 * gn + 3)));
    apb(`ASB_OFS_PTR, 1'b0, 8'h00);
    chk(rd, 32'h0);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk({31'h0, serial_irq_flag}, 32'h0);
    $display("Run done: %0d bytes, gap %0d, rx %0d, master %0d", nb, gn, rx, mst);
  endtask : run

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, irq_ack, wait_in_pin} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    presetn = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, ser_out_pin}, 32'h0);
    apb(8'h18, 1'b0, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(`ASB_OFS_PTR, 1'b1, 8'h05);
    apb(`ASB_OFS_PTR, 1'b0, 8'h00);
    chk(rd, 32'h5);
    $display("Register test done.");
    for (int i = 0; i < 4; i++) run(nb_t[i], gap_t[i], rx_t[i], mst_t[i]);
    close_out();
  end
endmodule : tb
`default_nettype wire
